// File: hdl/bgp_regs.svh
`ifndef BGP_REGS_SVH
`define BGP_REGS_SVH
// Register byte offsets
`define BGP_CTRL_OFF 12'h000
`define BGP_TARGET_OFF 12'h004
`define BGP_REFPOS_OFF 12'h008
`define BGP_OVERSHOOT_OFF 12'h00c
`define BGP_SLOWDIST_OFF 12'h010
`define BGP_STATUS_OFF 12'h014
`define BGP_POS_OFF 12'h018
`define BGP_STALL_OFF 12'h01c
`define BGP_IDENT_OFF 12'h020
// Control fields
`define BGP_CTRL_RUN 0
`define BGP_CTRL_FASTSLOW 1
`define BGP_CTRL_FAR 2
`define BGP_CTRL_STOP 3
`define BGP_CTRL_MM 4
`define BGP_CTRL_GO 5
`define BGP_CTRL_RESET 32'h0000_0000
// Defaults
`define BGP_OVERSHOOT_RST 32'h0000_2710
`define BGP_SLOWDIST_RST 32'h0000_03e8
`define BGP_STALL_RST 32'h0003_d090
// Position limits in counts of 0.01 in or 0.1 mm (999.99 in, 9999.9 mm)
`define BGP_MAX_IN 32'd99999
`define BGP_MAX_MM 32'd99999
`define BGP_OKAY 2'b00
`define BGP_SLVERR 2'b10
`endif

// File: hdl/bgp_pkg.sv
package bgp_pkg;
  typedef enum logic [1:0] {
    bgp_halt = 2'b00,
    bgp_fwd = 2'b01,
    bgp_rev = 2'b10
  } bgp_dir_t;
  typedef enum logic [3:0] {
    bgp_idle = 4'b0000,
    bgp_ref_start = 4'b0001,
    bgp_ref_off_fwd = 4'b0010,
    bgp_ref_seek_rev = 4'b0011,
    bgp_ref_over = 4'b0100,
    bgp_ref_wait = 4'b0101,
    bgp_ref_fwd = 4'b0110,
    bgp_move_rev = 4'b0111,
    bgp_move_fwd = 4'b1000,
    bgp_done = 4'b1001
  } bgp_state_t;
endpackage

// File: hdl/bgp_quad.sv
`timescale 1ns/100ps
// Synchronised 4x quadrature decoder; illegal double steps are ignored.
module bgp_quad
  import bgp_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic invert,
  output logic step_up,
  output logic step_dn
);
  logic [1:0] meta;
  logic [1:0] sync;
  logic [1:0] last;
  logic [1:0] cur;
  logic [1:0] prev;
  logic [1:0] delta;
  logic [2:0] live;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      meta <= 2'h0;
      sync <= 2'h0;
    end else begin
      meta <= {enc_a, enc_b};
      sync <= meta;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      last <= 2'h0;
    end else begin
      last <= sync;
    end
  end

  // Gray order 00,01,11,10; convert to binary phase
  assign cur = {sync[1], sync[1] ^ sync[0]};

  assign prev = {last[1], last[1] ^ last[0]};
  assign delta = cur - prev;

  // Steps stay quiet until the last sample holds a real pin level, so a reset never fakes a count
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      live <= 3'h0;
    end else begin
      live <= {live[1:0], 1'b1};
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn || !live[2]) begin
      step_up <= 1'b0;
      step_dn <= 1'b0;
    end else begin
      // Delta of 2 is an illegal jump and counts nothing
      step_up <= (delta == 2'h1) ^ (invert & (delta != 2'h2) & (delta != 2'h0));
      step_dn <= (delta == 2'h3) ^ (invert & (delta != 2'h2) & (delta != 2'h0));
    end
  end
endmodule

// File: hdl/bgp_outmap.sv
`timescale 1ns/100ps
// Maps the motion demand onto the four movement outputs.
module bgp_outmap
  import bgp_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic fast_slow,
  input wire logic running,
  input wire logic slow,
  input wire bgp_dir_t dir,
  output logic out_forward,
  output logic out_slow,
  output logic out_reverse,
  output logic out_run
);
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      out_forward <= 1'b0;
      out_slow <= 1'b0;
      out_reverse <= 1'b0;
      out_run <= 1'b0;
    end else begin
      out_reverse <= (dir == bgp_rev);
      out_run <= running && dir == bgp_fwd;
      if (fast_slow) begin
        out_forward <= dir == bgp_fwd && !(running && slow);
        out_slow <= running && slow && dir == bgp_fwd;
      end else begin
        out_forward <= dir == bgp_fwd;
        out_slow <= dir == bgp_halt || (running && slow && dir == bgp_fwd);
      end
    end
  end
endmodule

// File: hdl/bgp_top.sv
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
// How it works
// - Speed logic register bit picks forward-slow or fast-slow output encoding.
// - Forward-slow: fast run FOR+RUN, slow FOR+SLOW+RUN, halt SLOW only.
// - Fast-slow: fast FOR+RUN, slow SLOW+RUN, halt all off, jogs single.
// - Jogs and referencing always run at fast speed.
// - Near mode: home contact normally closed, open on or nearer than switch.
// - Far mode: home contact normally open, closed on or farther than switch.
// - Run with no reference first runs the referencing sequence.
// - Reference is captured only while travelling forward.
// - Near positive stop: drive forward, reference when stalled on the stop.
// - Far positive stop: reverse into stop, reference on first forward count.
// - Referencing loads the position counter with the reference position value.
// - Switch 4 off gives one speed, on gives two speed with slow.
// - Identity from switches 1,2,3,7; only 3 alone or 1 with 3 valid.
// - Drive and count continuously, stop drive when target reached.
// - Range up to 999.99 in or 9999.9 mm, units selectable.
// - Every quadrature edge counts: four counts per encoder line.
// - Part reset during a move finishes the move then goes to first bend.
module bgp_top
  import bgp_pkg::*;
#(
  parameter int STALL_DEFAULT = 250000
)
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic home_in,
  input wire logic jog_fwd_in,
  input wire logic jog_rev_in,
  input wire logic run_enable_in,
  input wire logic part_reset_in,
  input wire logic identity_switch_a,
  input wire logic identity_switch_b,
  input wire logic identity_switch_c,
  input wire logic speed_switch,
  input wire logic direction_switch,
  input wire logic identity_switch_g,
  output logic out_forward,
  output logic out_slow,
  output logic out_reverse,
  output logic out_run,
  output logic first_bend_req,
  output logic referenced
);
  `include "bgp_regs.svh"

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [10:0] pin_meta;
  logic [10:0] pin_sync;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pin_meta <= 11'h0;
      pin_sync <= 11'h0;
    end else begin
      pin_meta <= {home_in, jog_fwd_in, jog_rev_in, run_enable_in, part_reset_in, identity_switch_a,
                   identity_switch_b, identity_switch_c, speed_switch, direction_switch, identity_switch_g};
      pin_sync <= pin_meta;
    end
  end
  logic home_s, jogf_s, jogr_s, run_s, preset_s, two_speed;
  assign {home_s, jogf_s, jogr_s, run_s, preset_s} = pin_sync[10:6];
  assign two_speed = pin_sync[2];

  function automatic logic id_ok(input logic [10:0] p);
    id_ok = p[4] == 1'b0 && p[3] == 1'b1 && p[0] == 1'b0;
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [31:0] ctrl, target, ref_pos, overshoot, slow_dist, stall_lim;
  logic signed [31:0] pos;
  logic go_pulse;
  logic move_busy;
  logic limit_err;
  logic far_mode, pos_stop;
  assign far_mode = ctrl[`BGP_CTRL_FAR];
  assign pos_stop = ctrl[`BGP_CTRL_STOP];

  logic aw_held, w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        old[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    merge = old;
  endfunction

  logic do_write;
  assign do_write = aw_held && w_held;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `BGP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      case (aw_addr)
        `BGP_CTRL_OFF, `BGP_TARGET_OFF, `BGP_REFPOS_OFF, `BGP_OVERSHOOT_OFF, `BGP_SLOWDIST_OFF,
        `BGP_STALL_OFF: s_axi_bresp <= `BGP_OKAY;
        default: s_axi_bresp <= `BGP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ctrl <= `BGP_CTRL_RESET;
      target <= 32'h0;
      ref_pos <= 32'h0;
      overshoot <= `BGP_OVERSHOOT_RST;
      slow_dist <= `BGP_SLOWDIST_RST;
      stall_lim <= 32'(STALL_DEFAULT);
      go_pulse <= 1'b0;
    end else begin
      go_pulse <= 1'b0;
      if (do_write) begin
        case (aw_addr)
          `BGP_CTRL_OFF: begin
            ctrl <= merge(ctrl, w_data, w_strb);
            go_pulse <= w_strb[0] & w_data[`BGP_CTRL_GO];
          end
          `BGP_TARGET_OFF: target <= merge(target, w_data, w_strb);
          `BGP_REFPOS_OFF: ref_pos <= merge(ref_pos, w_data, w_strb);
          `BGP_OVERSHOOT_OFF: overshoot <= merge(overshoot, w_data, w_strb);
          `BGP_SLOWDIST_OFF: slow_dist <= merge(slow_dist, w_data, w_strb);
          `BGP_STALL_OFF: stall_lim <= merge(stall_lim, w_data, w_strb);
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `BGP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `BGP_OKAY;
      case (s_axi_araddr)
        `BGP_CTRL_OFF: s_axi_rdata <= ctrl;
        `BGP_TARGET_OFF: s_axi_rdata <= target;
        `BGP_REFPOS_OFF: s_axi_rdata <= ref_pos;
        `BGP_OVERSHOOT_OFF: s_axi_rdata <= overshoot;
        `BGP_SLOWDIST_OFF: s_axi_rdata <= slow_dist;
        `BGP_STATUS_OFF: s_axi_rdata <= {27'h0, limit_err, home_s, move_busy, referenced, id_ok(pin_sync)};
        `BGP_POS_OFF: s_axi_rdata <= pos;
        `BGP_STALL_OFF: s_axi_rdata <= stall_lim;
        `BGP_IDENT_OFF: s_axi_rdata <= {28'h0, pin_sync[0], pin_sync[3], pin_sync[4], pin_sync[5]};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= `BGP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Position counting
  // ----------------------------------------
  logic step_up, step_dn;
  bgp_quad u_quad (
    .mclk(mclk),
    .resetn(resetn),
    .enc_a(enc_a),
    .enc_b(enc_b),
    .invert(pin_sync[1]),
    .step_up(step_up),
    .step_dn(step_dn)
  );
  logic load_ref;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pos <= 32'sh0;
    end else if (load_ref) begin
      pos <= signed'(ref_pos);
    end else if (step_up) begin
      pos <= pos + 32'sh1;
    end else if (step_dn) begin
      pos <= pos - 32'sh1; // Forward travel counts toward the reference point
    end
  end

  // Stall timer: no count for stall_lim cycles means the gauge is at rest
  logic [31:0] still_cnt;
  logic stalled;
  logic stall_clr;
  always_ff @(posedge mclk) begin
    if (!resetn || step_up || step_dn || stall_clr) begin
      still_cnt <= 32'h0;
    end else if (still_cnt != stall_lim) begin
      still_cnt <= still_cnt + 32'h1;
    end
  end
  assign stalled = still_cnt == stall_lim;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  bgp_state_t state;
  bgp_dir_t dir;
  logic slow_now, pending_reset, home_last;
  logic signed [31:0] goal, limit;
  // A high pin is a closed contact: behind the switch in near mode, on or beyond it in far mode
  logic home_closed;
  assign home_closed = home_s;
  logic home_release;
  assign home_release = home_last && !home_closed;
  assign limit = ctrl[`BGP_CTRL_MM] ? signed'(`BGP_MAX_MM) : signed'(`BGP_MAX_IN);
  assign load_ref = (state == bgp_ref_fwd) && dir == bgp_fwd &&
                    (pos_stop ? (far_mode ? step_dn : stalled) : home_release);
  assign move_busy = state != bgp_idle && state != bgp_done;
  // A count left over from a long rest must not pass for a stall at the start of a seek
  assign stall_clr = state == bgp_ref_start;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      home_last <= 1'b0;
    end else begin
      home_last <= home_closed;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state <= bgp_idle;
      referenced <= 1'b0;
      goal <= 32'sh0;
      pending_reset <= 1'b0;
      first_bend_req <= 1'b0;
      limit_err <= 1'b0;
    end else begin
      first_bend_req <= 1'b0;
      if (preset_s && move_busy) begin
        pending_reset <= 1'b1;
      end
      if (!run_s || !ctrl[`BGP_CTRL_RUN]) begin
        state <= bgp_idle;
      end else begin
        case (state)
          bgp_idle, bgp_done: begin
            if (go_pulse || (state == bgp_idle && !referenced)) begin
              limit_err <= signed'(target) > limit;
              goal <= signed'(target);
              state <= referenced ? bgp_move_rev : bgp_ref_start;
            end
          end
          bgp_ref_start: begin
            if (pos_stop) begin
              state <= far_mode ? bgp_ref_seek_rev : bgp_ref_fwd;
            end else begin
              state <= home_closed ? (far_mode ? bgp_ref_off_fwd : bgp_ref_fwd) : bgp_ref_seek_rev;
            end
          end
          bgp_ref_off_fwd: if (!home_closed) state <= bgp_ref_seek_rev;
          bgp_ref_seek_rev: begin
            if (pos_stop ? stalled : home_closed) begin
              goal <= pos + signed'(overshoot);
              state <= pos_stop ? bgp_ref_fwd : bgp_ref_over;
            end
          end
          bgp_ref_over: if (pos >= goal) state <= bgp_ref_wait;
          bgp_ref_wait: if (stalled) state <= bgp_ref_fwd;
          bgp_ref_fwd: begin
            if (load_ref) begin
              referenced <= 1'b1;
              goal <= signed'(target);
              state <= bgp_move_rev;
            end
          end
          bgp_move_rev: begin
            // Targets are always approached forward to take up backlash
            if (pos > goal + signed'(overshoot)) state <= bgp_move_fwd;
          end
          bgp_move_fwd: begin
            if (pos <= goal) begin
              state <= bgp_done;
              first_bend_req <= pending_reset;
              // A part reset in this very cycle wins and carries over to the next move
              pending_reset <= preset_s;
            end
          end
          default: state <= bgp_idle;
        endcase
      end
    end
  end

  // Direction and speed demand
  always_comb begin
    dir = bgp_halt;
    slow_now = 1'b0;
    case (state)
      bgp_ref_off_fwd, bgp_ref_fwd: dir = bgp_fwd;
      bgp_ref_seek_rev, bgp_ref_over: dir = bgp_rev;
      bgp_move_rev: dir = bgp_rev;
      bgp_move_fwd: begin
        dir = bgp_fwd;
        slow_now = two_speed && (pos - goal) <= signed'(slow_dist);
      end
      bgp_idle: begin
        if (!ctrl[`BGP_CTRL_RUN] && jogf_s && !jogr_s) dir = bgp_fwd;
        if (!ctrl[`BGP_CTRL_RUN] && jogr_s && !jogf_s) dir = bgp_rev;
      end
      default: dir = bgp_halt;
    endcase
  end

  logic running;
  assign running = state == bgp_move_fwd || state == bgp_move_rev;

  bgp_outmap u_outmap (
    .mclk(mclk),
    .resetn(resetn),
    .fast_slow(ctrl[`BGP_CTRL_FASTSLOW]),
    .running(running),
    .slow(slow_now),
    .dir(dir),
    .out_forward(out_forward),
    .out_slow(out_slow),
    .out_reverse(out_reverse),
    .out_run(out_run)
  );
endmodule

// File: testbench/bgp_monitor.sv
`timescale 1ns/100ps
// ----
// Port checker for the backgauge controller
// ----
module bgp_monitor #(
  parameter int STALL_DEFAULT = 250000
)
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic run_enable_in,
  input wire logic jog_fwd_in,
  input wire logic jog_rev_in,
  input wire logic out_forward,
  input wire logic out_slow,
  input wire logic out_reverse,
  input wire logic out_run,
  input wire logic first_bend_req,
  input wire logic referenced
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_reset_quiet: assert property (disable iff (1'b0) !resetn |=>
    !(out_forward | out_slow | out_reverse | out_run | s_axi_bvalid | s_axi_rvalid | referenced))
    else $error("output active after reset");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response not held");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read response late");
  a_halt_quiet: assert property ((!run_enable_in && !jog_fwd_in && !jog_rev_in)[*6] |->
    !out_forward && !out_reverse && !out_run) else $error("movement while halted");
  a_rev_fast: assert property (out_reverse |-> !out_slow && !out_forward)
    else $error("reverse with slow or forward");
  a_ref_forward: assert property ($rose(referenced) |-> !out_reverse && !$past(out_reverse))
    else $error("reference taken in reverse");
  a_bend_pulse: assert property (first_bend_req |=> !first_bend_req)
    else $error("first bend request too long");

  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_ref: cover property ($rose(referenced));
  c_slow_run: cover property (out_slow && out_run);
  c_bend: cover property (first_bend_req);
endmodule

// File: testbench/bgp_drive_model.sv
`timescale 1ns/100ps
// ----
// Drive, positive stop, home contact and encoder
// ----
module bgp_drive_model #(
  parameter int HOME_AT = 100,
  parameter int PERIOD = 8
)
(
  input wire logic mclk,
  input wire logic out_forward,
  input wire logic out_slow,
  input wire logic out_reverse,
  input wire logic out_run,
  output logic enc_a,
  output logic enc_b,
  output logic home_in
);
  int phys = 200;
  int edges = 0;
  int div = 0;
  logic [1:0] q = 2'h0;
  // Slow period kept equal to fast so the stop lands within one step
  always @(posedge mclk) begin
    div <= (div + 1) % PERIOD;
    if (div == 0 && out_reverse === 1'b1) begin
      phys <= phys + 1;
      q <= q + 2'h1;
    end else if (div == 0 && (out_forward === 1'b1 || (out_slow & out_run) === 1'b1) && phys > 0) begin
      phys <= phys - 1;
      q <= q - 2'h1;
      edges <= edges + 1;
    end
  end
  // One gray step per move: four edges per line
  assign enc_a = q[1];
  assign enc_b = q[1] ^ q[0];
  // Closed contact opens nearer than the switch
  assign home_in = phys >= HOME_AT;
endmodule

// File: testbench/tb.sv
`timescale 1ns/100ps
`include "bgp_regs.svh"
`define CHK(a,e) begin cmp_count++; if ((a)!==(e)) begin err_total++; $display("BAD t=%0t got=%h exp=%h",$time,(a),(e)); end end
module tb;
  logic mclk = 1'b0, resetn = 1'b0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd, p0, ref_val, tgt;
  logic [3:0] s_axi_wstrb = 4'hf, sw, outs;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
  logic jog_fwd_in = '0, jog_rev_in = '0, run_enable_in = '0, part_reset_in = '0, speed_switch = '0;
  logic identity_switch_a = '0, identity_switch_b = '0, identity_switch_c = '0, identity_switch_g = '0;
  logic direction_switch = '0, ref_d = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, enc_a, enc_b, home_in;
  logic out_forward, out_slow, out_reverse, out_run, first_bend_req, referenced;
  logic [15:0] seed = 16'h0035;
  int err_total = 0, cmp_count = 0, bends = 0, rv = 0, sr = 0, rp = -1, rvb, e0;
  int d[2];
  assign outs = {out_forward, out_slow, out_reverse, out_run};

  bgp_top #(.STALL_DEFAULT(50)) bgp_top_inst (.mclk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .enc_a, .enc_b, .home_in, .jog_fwd_in, .jog_rev_in, .run_enable_in, .part_reset_in, .identity_switch_a,
    .identity_switch_b, .identity_switch_c, .speed_switch, .direction_switch, .identity_switch_g,
    .out_forward, .out_slow, .out_reverse, .out_run, .first_bend_req, .referenced);
  bgp_drive_model bgp_drive_model_inst (.mclk, .out_forward, .out_slow, .out_reverse, .out_run,
    .enc_a, .enc_b, .home_in);

  initial forever #2 mclk = ~mclk;

  always @(posedge mclk) begin
    ref_d <= referenced;
    if (referenced === 1'b1 && !ref_d) rp <= bgp_drive_model_inst.phys;
    if (out_reverse === 1'b1 && referenced !== 1'b1) rv <= rv + 1;
    if ((out_slow & out_run) === 1'b1) sr <= sr + 1;
    if (first_bend_req === 1'b1) bends <= bends + 1;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Motion code 0 halt, 1 jog forward, 2 jog reverse
  function automatic logic [3:0] exp_out(input logic fs, input int m);
    if (m == 1) return 4'h8;
    if (m == 2) return 4'h2;
    return fs ? 4'h0 : 4'h4;
  endfunction
  function automatic logic id_ok(input logic [3:0] s);
    return s[2] & ~s[1] & ~s[3];
  endfunction

  // ----
  // Bus tasks
  // ----
  task automatic clk(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic axw(input logic [11:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic axr(input logic [11:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic poll_idle;
    clk(6);
    do axr(`BGP_STATUS_OFF); while (rd[2] !== 1'b0);
  endtask
  task automatic print_verdict;
    $display("cmp_count=%0d err_total=%0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    #160000;
    err_total++;
    print_verdict;
  end

  // ----
  // Main sequence
  // ----
  initial begin
    clk(2);
    resetn <= 1'b1;
    clk(3);
    axr(`BGP_CTRL_OFF); `CHK(rd, `BGP_CTRL_RESET)
    axr(`BGP_OVERSHOOT_OFF); `CHK(rd, `BGP_OVERSHOOT_RST)
    axr(`BGP_SLOWDIST_OFF); `CHK(rd, `BGP_SLOWDIST_RST)
    axr(`BGP_STALL_OFF); `CHK(rd, 32'h0000_0032)
    axr(12'h0fc); `CHK(rs, `BGP_SLVERR)
    axw(12'h0f8, 32'h0000_00ff); `CHK(rs, `BGP_SLVERR)
    // Both legal identities first, then random settings
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      sw = (i < 2) ? {3'h2, i[0]} : seed[3:0];
      {identity_switch_g, identity_switch_c, identity_switch_b, identity_switch_a} <= sw;
      clk(6);
      axr(`BGP_IDENT_OFF); `CHK(rd[3:0], sw)
      axr(`BGP_STATUS_OFF); `CHK(rd[0], id_ok(sw))
    end
    {identity_switch_g, identity_switch_c, identity_switch_b, identity_switch_a} <= 4'h4;
    run_enable_in <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      direction_switch <= i[0];
      axw(`BGP_CTRL_OFF, 32'(i * 2));
      clk(8); `CHK(outs, exp_out(i[0], 0))
      axr(`BGP_POS_OFF);
      p0 = rd;
      e0 = bgp_drive_model_inst.edges;
      jog_fwd_in <= 1'b1;
      clk(8); `CHK(outs, exp_out(i[0], 1))
      clk(40);
      jog_fwd_in <= 1'b0;
      clk(20);
      axr(`BGP_POS_OFF);
      d[i] = int'(rd - p0);
      `CHK(32'(d[i] < 0 ? -d[i] : d[i]), 32'(bgp_drive_model_inst.edges - e0))
      jog_rev_in <= 1'b1;
      clk(8); `CHK(outs, exp_out(i[0], 2))
      clk(40);
      jog_rev_in <= 1'b0;
      clk(20);
    end
    `CHK(32'(d[0]), 32'(-d[1]))
    `CHK(d[0] == 0, 1'b0)
    direction_switch <= d[0] > 0;
    seed = lfsr(seed);
    ref_val = 32'h0000_0064 + seed[5:0];
    tgt = ref_val + 32'h0000_0096;
    axw(`BGP_OVERSHOOT_OFF, 32'h0000_0028);
    axw(`BGP_SLOWDIST_OFF, 32'h0000_0014);
    axw(`BGP_REFPOS_OFF, ref_val);
    axw(`BGP_TARGET_OFF, tgt);
    rvb = rv;
    // Run, fast-slow, near positive stop, go
    axw(`BGP_CTRL_OFF, 32'h0000_002b);
    poll_idle;
    `CHK(rd[1], 1'b1)
    `CHK(32'(rv), 32'(rvb))
    `CHK(32'(rp), 32'h0)
    axr(`BGP_POS_OFF); `CHK(rd, tgt)
    `CHK(32'(bgp_drive_model_inst.phys), tgt - ref_val)
    `CHK(32'(sr), 32'h0)
    speed_switch <= 1'b1;
    tgt = tgt - 32'h0000_003c;
    axw(`BGP_TARGET_OFF, tgt);
    axw(`BGP_CTRL_OFF, 32'h0000_002b);
    clk(20);
    part_reset_in <= 1'b1;
    clk(10);
    part_reset_in <= 1'b0;
    poll_idle;
    axr(`BGP_POS_OFF); `CHK(rd, tgt)
    `CHK(sr > 0, 1'b1)
    `CHK(32'(bends), 32'h1)
    // Reset after the move drops the reference; near home switch seen from its open side
    resetn <= 1'b0;
    clk(2);
    resetn <= 1'b1;
    clk(3);
    axr(`BGP_STATUS_OFF); `CHK(rd[1], 1'b0)
    rvb = rv;
    tgt = ref_val + 32'h0000_001e;
    axw(`BGP_OVERSHOOT_OFF, 32'h0000_0028);
    axw(`BGP_REFPOS_OFF, ref_val);
    axw(`BGP_TARGET_OFF, tgt);
    axw(`BGP_CTRL_OFF, 32'h0000_0021);
    poll_idle;
    `CHK(rd[1], 1'b1)
    `CHK(rv > rvb, 1'b1)
    `CHK(32'(rp), 32'(bgp_drive_model_inst.HOME_AT - 1))
    axr(`BGP_POS_OFF); `CHK(rd, tgt)
    print_verdict;
  end
endmodule
bind bgp_top bgp_monitor #(.STALL_DEFAULT(STALL_DEFAULT)) bgp_monitor_inst (.mclk, .resetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .run_enable_in, .jog_fwd_in, .jog_rev_in, .out_forward,
  .out_slow, .out_reverse, .out_run, .first_bend_req, .referenced);
